// [common/pss_pkg.sv]
package pss_pkg;

   // ---------------------------------------------------------------
   // Widths and depths
   // ---------------------------------------------------------------
   localparam int PC_W       = 13;    // Counter bits below the segment bit
   localparam int ADDR_W     = 14;    // Return path including segment bit
   localparam int CALL_W     = 11;    // Direct call reaches 0000H-07FFH
   localparam int SAVE_W     = 6;     // Bank bit plus five status flags
   localparam int PSW_W      = 5;
   localparam int SP_W       = 3;     // Low bits; the top bit is always zero
   localparam int ASR_DEPTH  = 5;
   localparam int SAVE_DEPTH = 3;
   localparam int OP_W       = 4;
   localparam int IRQ_SRC_W  = 3;
   localparam int EV_W       = 3;

   // ---------------------------------------------------------------
   // Reset values and limits
   // ---------------------------------------------------------------
   localparam logic [SP_W-1:0] SP_RESET = 3'h5;
   localparam logic [SP_W-1:0] SP_LIMIT = 3'h6;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic            CTRL_ENABLE_RESET = 1'b1;
   localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

   // ---------------------------------------------------------------
   // Interrupt sources and vectors (index = request bit)
   // ---------------------------------------------------------------
   localparam int SRC_BASIC  = 0;
   localparam int SRC_EXT    = 1;
   localparam int SRC_TIMER8 = 2;
   localparam logic [PC_W-1:0] VEC_BASIC  = 13'h0001;
   localparam logic [PC_W-1:0] VEC_EXT    = 13'h0002;
   localparam logic [PC_W-1:0] VEC_TIMER8 = 13'h0003;

   // ---------------------------------------------------------------
   // System call operand fields and their program counter positions
   // ---------------------------------------------------------------
   localparam int SYS_HI_W   = 3;
   localparam int SYS_LO_W   = 4;
   localparam int SYS_HI_SRC = 4;     // Operand bit of the high field
   localparam int SYS_HI_POS = 8;     // Counter bit of the high field
   localparam int SYS_LO_POS = 0;

   // ---------------------------------------------------------------
   // Sequencer operation codes
   // ---------------------------------------------------------------
   localparam logic [OP_W-1:0] OP_NEXT      = 4'h0;
   localparam logic [OP_W-1:0] OP_BR_ADDR   = 4'h1;
   localparam logic [OP_W-1:0] OP_CALL_ADDR = 4'h2;
   localparam logic [OP_W-1:0] OP_BR_AR     = 4'h3;
   localparam logic [OP_W-1:0] OP_CALL_AR   = 4'h4;
   localparam logic [OP_W-1:0] OP_SYSCALL   = 4'h5;
   localparam logic [OP_W-1:0] OP_TABLE1    = 4'h6;
   localparam logic [OP_W-1:0] OP_TABLE2    = 4'h7;
   localparam logic [OP_W-1:0] OP_RET       = 4'h8;
   localparam logic [OP_W-1:0] OP_RETURN_AND_SKIP     = 4'h9;
   localparam logic [OP_W-1:0] OP_INTERRUPT_RETURN      = 4'ha;
   localparam logic [OP_W-1:0] OP_PUSH_AR   = 4'hb;
   localparam logic [OP_W-1:0] OP_POP_AR    = 4'hc;

   // ---------------------------------------------------------------
   // Register map (byte offsets) and fields
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_STATE    = 4'h4;
   localparam logic [3:0] REG_IRQ_STAT = 4'h8;
   localparam logic [3:0] REG_IRQ_MASK = 4'hc;
   localparam int STATE_SP_POS    = 16;
   localparam int STATE_DEPTH_POS = 20;
   localparam int EV_OVERFLOW  = 0;
   localparam int EV_OVERWRITE = 1;
   localparam int EV_ACCEPT    = 2;

   typedef enum logic [1:0] {
      PSS_BUS_IDLE = 2'b01,
      PSS_BUS_ACK  = 2'b10
   } pss_bus_state_t;

endpackage

// [rtl/pss_save_stack.sv]
`timescale 1ns/1ps
module pss_save_stack #(
   parameter int DEPTH = pss_pkg::SAVE_DEPTH,
   parameter int WIDTH = pss_pkg::SAVE_W
)(
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             clear,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] pushData,
   output logic      [WIDTH-1:0] popData,
   output logic      [1:0]       depth,
   output logic                  overwrite
);

   // ---------------------------------------------------------------
   // Ring of entries
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] entry [DEPTH];
   logic [1:0]       top_reg;
   logic [1:0]       topDec;
   logic [1:0]       topInc;
   logic [1:0]       depth_reg;

   // Ring indices; a full ring reuses the oldest slot
   assign topDec    = (top_reg == 2'h0) ? 2'(DEPTH - 1) : top_reg - 2'h1;
   assign topInc    = (top_reg == 2'(DEPTH - 1)) ? 2'h0 : top_reg + 2'h1;
   assign popData   = entry[top_reg];
   assign depth     = depth_reg;
   assign overwrite = push && (depth_reg == 2'(DEPTH));

   // Counter moves down on save, up on restore
   always_ff @(posedge ref_clk) begin
      if (srst || clear) begin
         top_reg   <= 2'h0;
         depth_reg <= 2'h0;
      end else if (push) begin
         top_reg <= topDec;
         if (depth_reg != 2'(DEPTH)) begin
            depth_reg <= depth_reg + 2'h1;
         end
      end else if (pop) begin
         top_reg <= topInc;
         if (depth_reg != 2'h0) begin
            depth_reg <= depth_reg - 2'h1;
         end
      end
   end

   // One writer per slot
   for (genvar i = 0; i < DEPTH; i++) begin : gSlot
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            entry[i] <= '0;
         end else if (push && topDec == 2'(i)) begin
            entry[i] <= pushData;
         end
      end
   end

endmodule

// [rtl/pss_sequencer.sv]
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module pss_sequencer (
   input  wire logic                          ref_clk,
   input  wire logic                          srst,
   input  wire logic                          resetPinN,
   input  wire logic                          wdtReset,
   input  wire logic                          cmdValid,
   input  wire logic [pss_pkg::OP_W-1:0]      cmdOp,
   input  wire logic [pss_pkg::PC_W-1:0]      operand,
   input  wire logic [pss_pkg::ADDR_W-1:0]    addressRegister,
   input  wire logic                          intAccept,
   input  wire logic [pss_pkg::IRQ_SRC_W-1:0] intRequest,
   input  wire logic                          bankBit,
   input  wire logic [pss_pkg::PSW_W-1:0]     programStatusWord,
   input  wire logic [3:0]                    address,
   input  wire logic                          read,
   input  wire logic                          write,
   input  wire logic [31:0]                   writedata,
   input  wire logic [3:0]                    byteenable,
   output logic      [31:0]                   readdata,
   output logic                               waitrequest,
   output logic                               irq,
   output logic      [pss_pkg::PC_W-1:0]      pc,
   output logic                               segmentBit,
   output logic      [3:0]                    stackPointer,
   output logic                               skipNext,
   output logic                               restoreValid,
   output logic                               restoreBank,
   output logic      [pss_pkg::PSW_W-1:0]     restorePsw,
   output logic                               addrPopValid,
   output logic      [pss_pkg::ADDR_W-1:0]    addrPopData,
   output logic                               internalResetN
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic                          pinMeta_reg;
   logic                          pinSync_reg;
   logic                          coreReset;
   logic [pss_pkg::SP_W-1:0]      sp_reg;
   logic [pss_pkg::SP_W-1:0]      spDec;
   logic                          overLimit;
   logic                          overflow_reg;
   logic                          ctrlEnable_reg;
   logic [pss_pkg::EV_W-1:0]      status_reg;
   logic [pss_pkg::EV_W-1:0]      status_next;
   logic [pss_pkg::EV_W-1:0]      mask_reg;
   logic [pss_pkg::EV_W-1:0]      events;
   logic [pss_pkg::EV_W-1:0]      clearBits;
   pss_pkg::pss_bus_state_t       busState_reg;
   logic                          wrFire;
   logic [31:0]                   readMux;
   logic                          accept;
   logic                          opOk;
   logic                          isPush;
   logic                          isPop;
   logic                          isReti;
   logic [pss_pkg::PC_W-1:0]      vector;
   logic [pss_pkg::PC_W-1:0]      sysEntry;
   logic [pss_pkg::ADDR_W-1:0]    returnAddr;
   logic [pss_pkg::ADDR_W-1:0]    pushValue;
   logic [pss_pkg::ADDR_W-1:0]    stackTop;
   logic [pss_pkg::ADDR_W-1:0]    return_address_stack [pss_pkg::ASR_DEPTH];
   logic [pss_pkg::SAVE_W-1:0]    savePop;
   logic [1:0]                    saveDepth;
   logic                          saveOverwrite;

   // ---------------------------------------------------------------
   // Reset sources
   // ---------------------------------------------------------------

   // Reset pin is asynchronous to the core clock
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pinMeta_reg <= 1'b1;
         pinSync_reg <= 1'b1;
      end else begin
         pinMeta_reg <= resetPinN;
         pinSync_reg <= pinMeta_reg;
      end
   end

   assign overLimit = (sp_reg >= pss_pkg::SP_LIMIT);

   // Registered so the overflow reset is one clean pulse, not a loop
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         overflow_reg   <= 1'b0;
         internalResetN <= 1'b1;
      end else begin
         overflow_reg   <= overLimit;
         internalResetN <= ~overLimit;
      end
   end

   // every reset source clears the core
   assign coreReset = srst || !pinSync_reg || wdtReset || overflow_reg;

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------

   // An accepted interrupt takes the cycle; a command beside it is dropped
   assign accept = intAccept && (|intRequest) && ctrlEnable_reg && !coreReset;
   assign opOk   = cmdValid && ctrlEnable_reg && !accept && !coreReset;
   assign isReti = opOk && (cmdOp == pss_pkg::OP_INTERRUPT_RETURN);

   always_comb begin
      isPush = 1'b0;
      isPop  = 1'b0;
      if (opOk) begin
         case (cmdOp)
            pss_pkg::OP_CALL_ADDR,
            pss_pkg::OP_CALL_AR,
            pss_pkg::OP_SYSCALL,
            pss_pkg::OP_PUSH_AR,
            pss_pkg::OP_TABLE1: isPush = 1'b1;
            pss_pkg::OP_RET,
            pss_pkg::OP_RETURN_AND_SKIP,
            pss_pkg::OP_POP_AR,
            pss_pkg::OP_TABLE2,
            pss_pkg::OP_INTERRUPT_RETURN: isPop = 1'b1;
            default: ;
         endcase
      end
   end

   always_comb begin
      if (intRequest[pss_pkg::SRC_TIMER8]) begin
         vector = pss_pkg::VEC_TIMER8;
      end else if (intRequest[pss_pkg::SRC_EXT]) begin
         vector = pss_pkg::VEC_EXT;
      end else begin
         vector = pss_pkg::VEC_BASIC;
      end
   end

   always_comb begin
      sysEntry = '0;
      sysEntry[pss_pkg::SYS_HI_POS +: pss_pkg::SYS_HI_W] =
         operand[pss_pkg::SYS_HI_SRC +: pss_pkg::SYS_HI_W];
      sysEntry[pss_pkg::SYS_LO_POS +: pss_pkg::SYS_LO_W] =
         operand[0 +: pss_pkg::SYS_LO_W];
   end

   // ---------------------------------------------------------------
   // Address stack
   // ---------------------------------------------------------------
   assign returnAddr = {segmentBit, pc + 13'h0001};
   assign spDec      = sp_reg - 3'h1;

   assign pushValue = (opOk && cmdOp == pss_pkg::OP_PUSH_AR) ? addressRegister : returnAddr;

   // Slots five to seven do not exist and read as zero
   assign stackTop = (sp_reg < 3'(pss_pkg::ASR_DEPTH)) ? return_address_stack[sp_reg] : '0;

   always_ff @(posedge ref_clk) begin
      if (coreReset) begin
         sp_reg <= pss_pkg::SP_RESET;
      end else if (isPush || accept) begin
         sp_reg <= spDec;
      end else if (isPop) begin
         sp_reg <= sp_reg + 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stackPointer <= {1'b0, pss_pkg::SP_RESET};
      end else if (coreReset) begin
         stackPointer <= {1'b0, pss_pkg::SP_RESET};
      end else if (isPush || accept) begin
         stackPointer <= {1'b0, spDec};
      end else if (isPop) begin
         stackPointer <= {1'b0, sp_reg + 3'h1};
      end
   end

   // entry written at the decremented pointer
   for (genvar i = 0; i < pss_pkg::ASR_DEPTH; i++) begin : gAsr
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            return_address_stack[i] <= '0;
         end else if ((isPush || accept) && spDec == 3'(i)) begin
            return_address_stack[i] <= pushValue;
         end
      end
   end

   // Popped address register contents for the register file
   always_ff @(posedge ref_clk) begin
      if (coreReset) begin
         addrPopValid <= 1'b0;
         addrPopData  <= '0;
      end else begin
         addrPopValid <= opOk && cmdOp == pss_pkg::OP_POP_AR;
         addrPopData  <= stackTop;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt save stack
   // ---------------------------------------------------------------

   // save on accept, restore on return
   pss_save_stack #(
      .DEPTH (pss_pkg::SAVE_DEPTH),
      .WIDTH (pss_pkg::SAVE_W)
   ) uSave (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .clear     (coreReset),
      .push      (accept),
      .pop       (isReti),
      .pushData  ({bankBit, programStatusWord}),
      .popData   (savePop),
      .depth     (saveDepth),
      .overwrite (saveOverwrite)
   );

   always_ff @(posedge ref_clk) begin
      if (coreReset) begin
         restoreValid <= 1'b0;
         restoreBank  <= 1'b0;
         restorePsw   <= '0;
      end else begin
         restoreValid <= isReti;
         restoreBank  <= savePop[pss_pkg::PSW_W];
         restorePsw   <= savePop[pss_pkg::PSW_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Program counter and segment bit
   // ---------------------------------------------------------------

   always_ff @(posedge ref_clk) begin
      if (coreReset) begin
         pc <= pss_pkg::PC_RESET;
      end else if (accept) begin
         pc <= vector;
      end else if (opOk) begin
         case (cmdOp)
            pss_pkg::OP_BR_ADDR: pc <= operand;
            pss_pkg::OP_CALL_ADDR: pc <= {2'b00, operand[pss_pkg::CALL_W-1:0]};
            pss_pkg::OP_BR_AR,
            pss_pkg::OP_CALL_AR,
            pss_pkg::OP_TABLE1: pc <= addressRegister[pss_pkg::PC_W-1:0];
            pss_pkg::OP_SYSCALL: pc <= sysEntry;
            pss_pkg::OP_RET,
            pss_pkg::OP_RETURN_AND_SKIP,
            pss_pkg::OP_INTERRUPT_RETURN,
            pss_pkg::OP_TABLE2: pc <= stackTop[pss_pkg::PC_W-1:0];
            default: pc <= pc + 13'h0001;
         endcase
      end
   end

   // set by OP_BR_AR, OP_CALL_AR, syscall, returns and OP_TABLE2; an accept clears it
   always_ff @(posedge ref_clk) begin
      if (coreReset) begin
         segmentBit <= 1'b0;
      end else if (accept) begin
         segmentBit <= 1'b0;
      end else if (opOk) begin
         case (cmdOp)
            pss_pkg::OP_BR_AR,
            pss_pkg::OP_CALL_AR: segmentBit <= addressRegister[pss_pkg::PC_W];
            pss_pkg::OP_SYSCALL: segmentBit <= 1'b1;
            pss_pkg::OP_RET,
            pss_pkg::OP_RETURN_AND_SKIP,
            pss_pkg::OP_INTERRUPT_RETURN,
            pss_pkg::OP_TABLE2: segmentBit <= stackTop[pss_pkg::PC_W];
            default: segmentBit <= segmentBit;
         endcase
      end
   end

   // skip flag lives for one instruction
   always_ff @(posedge ref_clk) begin
      if (coreReset) begin
         skipNext <= 1'b0;
      end else if (opOk) begin
         skipNext <= (cmdOp == pss_pkg::OP_RETURN_AND_SKIP);
      end else if (accept) begin
         skipNext <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Event status and interrupt
   // ---------------------------------------------------------------
   assign events[pss_pkg::EV_OVERFLOW]  = overLimit && !overflow_reg;
   assign events[pss_pkg::EV_OVERWRITE] = saveOverwrite;
   assign events[pss_pkg::EV_ACCEPT]    = accept;

   // Write one to clear; a new event in the same cycle wins
   assign clearBits = (wrFire && address == pss_pkg::REG_IRQ_STAT && byteenable[0])
                    ? writedata[pss_pkg::EV_W-1:0] : '0;
   assign status_next = (status_reg & ~clearBits) | events;

   // Status survives core resets so software can see the cause
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         status_reg <= '0;
         irq        <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq        <= |(status_next & mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // Avalon-MM slave
   // ---------------------------------------------------------------
   assign wrFire = (busState_reg == pss_pkg::PSS_BUS_ACK) && write;

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      readMux = '0;
      case (address)
         pss_pkg::REG_CTRL: readMux[0] = ctrlEnable_reg;
         pss_pkg::REG_STATE: begin
            readMux[pss_pkg::ADDR_W-1:0] = {segmentBit, pc};
            readMux[pss_pkg::STATE_SP_POS +: 4] = stackPointer;
            readMux[pss_pkg::STATE_DEPTH_POS +: 2] = saveDepth;
         end
         pss_pkg::REG_IRQ_STAT: readMux[pss_pkg::EV_W-1:0] = status_reg;
         pss_pkg::REG_IRQ_MASK: readMux[pss_pkg::EV_W-1:0] = mask_reg;
         default: readMux = '0;
      endcase
   end

   // One wait cycle, then a single acknowledge cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         busState_reg <= pss_pkg::PSS_BUS_IDLE;
         waitrequest  <= 1'b1;
         readdata     <= '0;
      end else begin
         case (busState_reg)
            pss_pkg::PSS_BUS_IDLE: begin
               if (read || write) begin
                  busState_reg <= pss_pkg::PSS_BUS_ACK;
                  waitrequest  <= 1'b0;
                  readdata     <= read ? readMux : '0;
               end
            end
            pss_pkg::PSS_BUS_ACK: begin
               busState_reg <= pss_pkg::PSS_BUS_IDLE;
               waitrequest  <= 1'b1;
            end
            default: begin
               busState_reg <= pss_pkg::PSS_BUS_IDLE;
               waitrequest  <= 1'b1;
            end
         endcase
      end
   end

   // Control and mask registers, low byte lane only
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrlEnable_reg <= pss_pkg::CTRL_ENABLE_RESET;
         mask_reg       <= pss_pkg::MASK_RESET;
      end else if (wrFire && byteenable[0]) begin
         if (address == pss_pkg::REG_CTRL) begin
            ctrlEnable_reg <= writedata[0];
         end
         if (address == pss_pkg::REG_IRQ_MASK) begin
            mask_reg <= writedata[pss_pkg::EV_W-1:0];
         end
      end
   end

endmodule

// [bench/pss_sequencer_props.sv]
`timescale 1ns/1ps
module pss_sequencer_props (
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        wdtReset,
   input wire logic        cmdValid,
   input wire logic [3:0]  cmdOp,
   input wire logic [12:0] operand,
   input wire logic        intAccept,
   input wire logic [2:0]  intRequest,
   input wire logic [12:0] pc,
   input wire logic        segmentBit,
   input wire logic [3:0]  stackPointer,
   input wire logic        internalResetN
);
   // ---------------------------------
   // Qualified events
   // ---------------------------------
   // Core reset cycles excluded except pin resets, they override every command
   wire ok = internalResetN && !wdtReset && stackPointer < 4'h6;
   wire acc = ok && intAccept && |intRequest;
   wire cmd = ok && cmdValid && !(intAccept && |intRequest);
   wire dn = acc || cmd && cmdOp inside {4'h2, 4'h4, 4'h5, 4'h6, 4'hb};
   wire up = cmd && cmdOp inside {4'h7, 4'h8, 4'h9, 4'ha, 4'hc};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   AST_VEC: assert property (acc |=> !segmentBit && pc == ($past(intRequest[2]) ? 13'h3 :
      $past(intRequest[1]) ? 13'h2 : 13'h1)) else $error("vector");
   AST_CALL: assert property (cmd && cmdOp == 4'h2 |=> pc == {2'h0, $past(operand[10:0])})
      else $error("call target");
   AST_SYS: assert property (cmd && cmdOp == 4'h5 |=> segmentBit &&
      pc == {2'h0, $past(operand[6:4]), 4'h0, $past(operand[3:0])}) else $error("syscall");
   AST_DOWN: assert property (dn |=> stackPointer[2:0] == $past(stackPointer[2:0]) - 3'h1)
      else $error("pointer down");
   AST_UP: assert property (up |=> stackPointer[2:0] == $past(stackPointer[2:0]) + 3'h1)
      else $error("pointer up");
   AST_TOP: assert property (!stackPointer[3]) else $error("pointer top bit");
   AST_OVF: assert property (stackPointer > 4'h5 |-> ##[1:2] !internalResetN) else $error("overflow");
   AST_CRST: assert property ($fell(internalResetN) |-> ##[0:2] pc == 13'h0 &&
      stackPointer == 4'h5 && !segmentBit) else $error("core reset");
   AST_NEXT: assert property (cmd && cmdOp == 4'h0 |=> pc == $past(pc) + 13'h1 &&
      $stable(segmentBit)) else $error("increment");
   CV_ACC: cover property (acc);
   CV_SYS: cover property (cmd && cmdOp == 4'h5);
   CV_OVF: cover property (!internalResetN);
endmodule
bind pss_sequencer pss_sequencer_props u_props (.ref_clk(ref_clk), .srst(srst), .wdtReset(wdtReset),
   .cmdValid(cmdValid), .cmdOp(cmdOp), .operand(operand), .intAccept(intAccept), .intRequest(intRequest),
   .pc(pc), .segmentBit(segmentBit), .stackPointer(stackPointer), .internalResetN(internalResetN));

// [bench/program_sequencer_stack_tb_top.sv]
`timescale 1ns/1ps
module program_sequencer_stack_tb_top;
   logic ref_clk = 0, srst = 1, wdtReset = 0, cmdValid = 0, intAccept = 0, bankBit = 0, read = 0, write = 0;
   logic [3:0] cmdOp = 0, address = 0, stackPointer;
   logic [12:0] operand = 0, pc;
   logic [13:0] addressRegister = 0, addrPopData;
   logic [2:0] intRequest = 0;
   logic [4:0] psw = 0, restorePsw;
   logic [31:0] writedata = 0, readdata, rd;
   logic waitrequest, irq, segmentBit, skipNext, restoreValid, restoreBank, addrPopValid, internalResetN;
   int errTotal = 0, samplesChecked = 0;
   logic pinN = 1;
   pss_sequencer DUT (.ref_clk(ref_clk), .srst(srst), .resetPinN(pinN), .wdtReset(wdtReset),
      .cmdValid(cmdValid), .cmdOp(cmdOp), .operand(operand), .addressRegister(addressRegister),
      .intAccept(intAccept), .intRequest(intRequest), .bankBit(bankBit), .programStatusWord(psw),
      .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
      .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .pc(pc), .segmentBit(segmentBit),
      .stackPointer(stackPointer), .skipNext(skipNext), .restoreValid(restoreValid),
      .restoreBank(restoreBank), .restorePsw(restorePsw), .addrPopValid(addrPopValid),
      .addrPopData(addrPopData), .internalResetN(internalResetN));
   // ---------------------------------
   // Shared drivers
   // ---------------------------------
   always #20 ref_clk = ~ref_clk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samplesChecked++;
      if (g !== e) begin
         errTotal++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic st(input logic [12:0] p, input logic s, input logic [3:0] q);
      chk({segmentBit, stackPointer, pc}, {s, q, p});
   endtask
   // Held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge ref_clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      r = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   // One command or accept; accept carries request, bank, flags in v
   task automatic op(input logic i, input logic [3:0] o, input logic [12:0] v);
      @(posedge ref_clk);
      intAccept <= i;
      cmdValid <= !i;
      cmdOp <= o;
      operand <= v;
      intRequest <= v[2:0];
      {bankBit, psw} <= v[8:3];
      @(posedge ref_clk);
      intAccept <= 1'b0;
      cmdValid <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic crst;
      @(posedge ref_clk);
      wdtReset <= 1'b1;
      @(posedge ref_clk);
      wdtReset <= 1'b0;
      @(negedge ref_clk);
      st(13'h0, 1'b0, 4'h5);
   endtask
   // ---------------------------------
   // Scenarios
   // ---------------------------------
   task automatic t_reg;
      crst();
      bus(1'b1, pss_pkg::REG_STATE, 32'hffff, rd);
      bus(1'b0, pss_pkg::REG_STATE, 32'h0, rd);
      chk(rd, 32'h0005_0000);
      bus(1'b0, pss_pkg::REG_CTRL, 32'h0, rd);
      chk(rd, 32'h1);
      bus(1'b0, 4'h2, 32'h0, rd);
      chk(rd, 32'h0);
   endtask
   task automatic t_call;
      crst();
      op(1'b0, 4'h0, 13'h0);
      op(1'b0, 4'h2, 13'h1abc);
      st(13'h02bc, 1'b0, 4'h4);
      op(1'b0, 4'h8, 13'h0);
      st(13'h2, 1'b0, 4'h5);
      op(1'b0, 4'h5, 13'h005a);
      st(13'h050a, 1'b1, 4'h4);
      op(1'b0, 4'h9, 13'h0);
      st(13'h3, 1'b0, 4'h5);
      chk(skipNext, 1'b1);
   endtask
   task automatic t_ar;
      crst();
      @(posedge ref_clk) addressRegister <= 14'h3abc;
      op(1'b0, 4'h4, 13'h0);
      st(13'h1abc, 1'b1, 4'h4);
      op(1'b0, 4'h6, 13'h0);
      op(1'b0, 4'h7, 13'h0);
      st(13'h1abd, 1'b1, 4'h4);
      op(1'b0, 4'h8, 13'h0);
      st(13'h1, 1'b0, 4'h5);
      @(posedge ref_clk) addressRegister <= 14'h1555;
      op(1'b0, 4'hb, 13'h0);
      op(1'b0, 4'hc, 13'h0);
      chk({addrPopValid, addrPopData}, {1'b1, 14'h1555});
   endtask
   // Four nested accepts overrun the three save slots
   task automatic t_int;
      logic [5:0] sv [4] = '{6'h21, 6'h0a, 6'h35, 6'h1e};
      logic [2:0] rq [4] = '{3'h7, 3'h6, 3'h1, 3'h2};
      logic [12:0] vc [4] = '{13'h3, 13'h3, 13'h1, 13'h2};
      crst();
      for (int k = 0; k < 4; k++) begin
         op(1'b1, 4'h0, {4'h0, sv[k], rq[k]});
         st(vc[k], 1'b0, 4'h4 - 4'(k));
      end
      bus(1'b0, pss_pkg::REG_IRQ_STAT, 32'h0, rd);
      chk(rd, 32'h6);
      chk(irq, 1'b0);
      bus(1'b1, pss_pkg::REG_IRQ_MASK, 32'h4, rd);
      repeat (2) @(negedge ref_clk);
      chk(irq, 1'b1);
      bus(1'b1, pss_pkg::REG_IRQ_STAT, 32'h4, rd);
      repeat (2) @(negedge ref_clk);
      chk(irq, 1'b0);
      for (int k = 3; k > 0; k--) begin
         op(1'b0, 4'ha, 13'h0);
         chk({restoreValid, restoreBank, restorePsw}, {1'b1, sv[k]});
      end
      chk(stackPointer, 4'h4);
   endtask
   task automatic t_ovf;
      crst();
      repeat (6) op(1'b0, 4'h2, 13'h0100);
      st(13'h0100, 1'b0, 4'h7);
      @(negedge ref_clk);
      chk(internalResetN, 1'b0);
      @(negedge ref_clk);
      st(13'h0, 1'b0, 4'h5);
      bus(1'b0, pss_pkg::REG_IRQ_STAT, 32'h0, rd);
      chk(rd[0], 1'b1);
   endtask
   // Pin reset passes the synchroniser, then clears the core
   task automatic t_pin;
      op(1'b0, 4'h5, 13'h0011);
      @(posedge ref_clk) pinN <= 1'b0;
      repeat (4) @(posedge ref_clk);
      pinN <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      st(13'h0, 1'b0, 4'h5);
   endtask
   task automatic summarize;
      if (errTotal == 0 && samplesChecked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      t_reg();
      t_call();
      t_ar();
      t_int();
      t_ovf();
      t_pin();
      summarize();
   end
   // Watchdog at 5000 cycles, far beyond the roughly 120 cycles needed
   initial begin
      #200000;
      errTotal++;
      summarize();
   end
endmodule
